// *** core/mcp_pkg.sv ***
// constants for the host control input and first port block
// assumes one clock domain, core_clk at 125 MHz
package mcp_pkg;
    localparam int PORT_W = 8;
    // first control input roles
    typedef enum logic [1:0] {
        MCP_C1_READ_LOW   = 2'b00,
        MCP_C1_PHASE_CLK  = 2'b01,
        MCP_C1_STROBE_LOW = 2'b10,
        MCP_C1_FETCH_LOW  = 2'b11
    } mcp_c1_mode_e;
    // second control input roles
    typedef enum logic [0:0] {
        MCP_C2_FETCH   = 1'b0,
        MCP_C2_GENERIC = 1'b1
    } mcp_c2_mode_e;
    // per-pin function of the first port
    localparam logic [1:0] PIN_HOST_OUT  = 2'h0;
    localparam logic [1:0] PIN_HOST_IN   = 2'h1;
    localparam logic [1:0] PIN_MACROCELL = 2'h2;
    localparam logic [1:0] PIN_LOGIC_IN  = 2'h3;
    localparam logic [1:0] PIN_FUNC_RST  = PIN_HOST_IN;
    localparam logic [7:0] PORT_DATA_RST = 8'h00;
    // flash run states
    typedef enum logic [1:0] {
        MCP_FL_IDLE  = 2'b00,
        MCP_FL_BUSY  = 2'b01,
        MCP_FL_ABORT = 2'b10
    } mcp_flash_e;
endpackage : mcp_pkg

// *** core/mcp_sync2.sv ***
// two-stage synchroniser for a bus of pin inputs
// assumes inputs are asynchronous to core_clk
`timescale 1ns/10ps
module mcp_sync2 #(
    parameter int W = 1
) (
    // clock
    input  wire logic         core_clk,
    // data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage_one;

    always_ff @(posedge core_clk) begin
        stage_one <= din;
        dout      <= stage_one;
    end
endmodule : mcp_sync2

// *** core/mcp_control_port.sv ***
// host control inputs, reset handling and first port function select
// assumes host pins are asynchronous; config and flash come from core logic
// Behaviour
// - first control input serves as read strobe, phase clock or data strobe
// - fetch select routed to first input acts as active-low read
// - second control input accepts a code-only fetch select
// - without fetch select the second input is a general logic input
// - both control inputs feed the logic arrays as equation terms
// - reset clears port data and pin outputs and loads the default config
// - reset aborts a flash program or erase in progress
// - each first-port pin can be a host output or input bit
// - each pin can be driven by its macrocell or feed the logic arrays
`timescale 1ns/10ps
module mcp_control_port (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // host control pins
    input  wire logic                    bus_control_input_one,
    input  wire logic                    bus_control_input_two,
    // stored configuration
    input  wire logic [1:0]              cfg_c1_mode,
    input  wire logic                    cfg_c2_mode,
    input  wire logic [15:0]             cfg_pin_func,
    // host port access
    input  wire logic                    host_port_wr,
    input  wire logic [7:0]              host_port_wdata,
    // macrocells
    input  wire logic [7:0]              first_port_macrocells,
    // flash engine
    input  wire logic                    flash_start,
    input  wire logic                    flash_done,
    // first port pins
    input  wire logic [7:0]              first_port_pins_in,
    output logic      [7:0]              first_port_pins_out,
    output logic      [7:0]              first_port_pins_oe,
    // results
    output logic      [7:0]              host_port_rdata,
    output logic      [7:0]              logic_array_port_in,
    output logic                         read_low,
    output logic                         phase_clk,
    output logic                         data_strobe_low,
    output logic                         program_fetch_select,
    output logic                         generic_input,
    output logic                         logic_term_one,
    output logic                         logic_term_two,
    output logic                         flash_busy,
    output logic                         flash_aborted
);
    logic [1:0]                 ctl_sync;
    logic [7:0]                 pin_sync;
    logic [7:0]                 port_data;
    logic [15:0]                pin_func;
    logic                       cfg_loaded;
    mcp_pkg::mcp_c1_mode_e      c1_mode;
    mcp_pkg::mcp_c2_mode_e      c2_mode;
    mcp_pkg::mcp_flash_e        fl_state;
    mcp_pkg::mcp_flash_e        next_fl_state;

    mcp_sync2 #(.W(10)) u_sync (
        .core_clk (core_clk),
        .din      ({first_port_pins_in, bus_control_input_two, bus_control_input_one}),
        .dout     ({pin_sync, ctl_sync})
    );

    // config latched one cycle after release so reset cannot be bypassed
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_loaded <= 1'b0;
            c1_mode    <= mcp_pkg::MCP_C1_READ_LOW;
            c2_mode    <= mcp_pkg::MCP_C2_FETCH;
            pin_func   <= {mcp_pkg::PORT_W{mcp_pkg::PIN_FUNC_RST}};
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            c1_mode    <= mcp_pkg::mcp_c1_mode_e'(cfg_c1_mode);
            c2_mode    <= mcp_pkg::mcp_c2_mode_e'(cfg_c2_mode);
            pin_func   <= cfg_pin_func;
        end
    end

    // first control input decode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            read_low        <= 1'b1;
            phase_clk       <= 1'b0;
            data_strobe_low <= 1'b1;
        end else begin
            read_low        <= 1'b1;
            phase_clk       <= 1'b0;
            data_strobe_low <= 1'b1;
            case (c1_mode)
                mcp_pkg::MCP_C1_READ_LOW:   read_low        <= ctl_sync[0];
                mcp_pkg::MCP_C1_PHASE_CLK:  phase_clk       <= ctl_sync[0];
                mcp_pkg::MCP_C1_STROBE_LOW: data_strobe_low <= ctl_sync[0];
                mcp_pkg::MCP_C1_FETCH_LOW:  read_low        <= ctl_sync[0];
                default:                    read_low        <= 1'b1;
            endcase
        end
    end

    // second control input decode and logic array terms
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            program_fetch_select <= 1'b1;
            generic_input        <= 1'b0;
            logic_term_one       <= 1'b0;
            logic_term_two       <= 1'b0;
        end else begin
            logic_term_one <= ctl_sync[0];
            logic_term_two <= ctl_sync[1];
            if (c2_mode == mcp_pkg::MCP_C2_FETCH) begin
                program_fetch_select <= ctl_sync[1];
                generic_input        <= 1'b0;
            end else begin
                program_fetch_select <= 1'b1;
                generic_input        <= ctl_sync[1];
            end
        end
    end

    // host port data latch
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_data <= mcp_pkg::PORT_DATA_RST;
        end else if (host_port_wr) begin
            port_data <= host_port_wdata;
        end
    end

    // per-pin function mux; pins stay released until config is applied
    genvar gi;
    generate
        for (gi = 0; gi < mcp_pkg::PORT_W; gi++) begin : g_pin
            logic [1:0] func;
            assign func = pin_func[2*gi +: 2];
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    first_port_pins_out[gi] <= 1'b0;
                    first_port_pins_oe[gi]  <= 1'b0;
                    host_port_rdata[gi]     <= 1'b0;
                    logic_array_port_in[gi] <= 1'b0;
                end else begin
                    first_port_pins_out[gi] <= 1'b0;
                    first_port_pins_oe[gi]  <= 1'b0;
                    host_port_rdata[gi]     <= 1'b0;
                    logic_array_port_in[gi] <= 1'b0;
                    case (func)
                        mcp_pkg::PIN_HOST_OUT: begin
                            first_port_pins_out[gi] <= port_data[gi];
                            first_port_pins_oe[gi]  <= cfg_loaded;
                            host_port_rdata[gi]     <= port_data[gi];
                        end
                        mcp_pkg::PIN_HOST_IN: begin
                            host_port_rdata[gi]     <= pin_sync[gi];
                        end
                        mcp_pkg::PIN_MACROCELL: begin
                            first_port_pins_out[gi] <= first_port_macrocells[gi];
                            first_port_pins_oe[gi]  <= cfg_loaded;
                        end
                        mcp_pkg::PIN_LOGIC_IN: begin
                            logic_array_port_in[gi] <= pin_sync[gi];
                        end
                        default: first_port_pins_oe[gi] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // flash cycle tracking; an abort stays visible until the next start
    always_comb begin
        next_fl_state = fl_state;
        case (fl_state)
            mcp_pkg::MCP_FL_IDLE: begin
                if (flash_start) begin
                    next_fl_state = mcp_pkg::MCP_FL_BUSY;
                end
            end
            mcp_pkg::MCP_FL_BUSY: begin
                if (flash_done) begin
                    next_fl_state = mcp_pkg::MCP_FL_IDLE;
                end
            end
            mcp_pkg::MCP_FL_ABORT: begin
                if (flash_start) begin
                    next_fl_state = mcp_pkg::MCP_FL_BUSY;
                end
            end
            default: next_fl_state = mcp_pkg::MCP_FL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            // a long reset must not turn an abort back into idle
            if (fl_state != mcp_pkg::MCP_FL_IDLE) begin
                fl_state <= mcp_pkg::MCP_FL_ABORT;
            end else begin
                fl_state <= mcp_pkg::MCP_FL_IDLE;
            end
        end else begin
            fl_state <= next_fl_state;
        end
    end

    // flags cleared in reset; the abort shows once reset lets go
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_busy <= 1'b0;
        end else begin
            flash_busy <= (fl_state == mcp_pkg::MCP_FL_BUSY);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_aborted <= 1'b0;
        end else begin
            flash_aborted <= (fl_state == mcp_pkg::MCP_FL_ABORT);
        end
    end
endmodule : mcp_control_port

// *** tb/mcp_chk_assertions.sv ***
// checker for the control input and first port block
// assumes one clock; bound to every mcp_control_port
`timescale 1ns/10ps
module mcp_chk (
    input wire logic        core_clk, rst_n, host_port_wr, flash_busy, flash_aborted,
    input wire logic        bus_control_input_one, bus_control_input_two, cfg_c2_mode,
    input wire logic [1:0]  cfg_c1_mode,
    input wire logic [15:0] cfg_pin_func,
    input wire logic [7:0]  host_port_wdata, first_port_pins_in, first_port_pins_out,
    input wire logic [7:0]  first_port_pins_oe, logic_array_port_in,
    input wire logic        read_low, phase_clk, data_strobe_low, program_fetch_select,
    input wire logic        generic_input, logic_term_one, logic_term_two
);
    logic [2:0]  up;
    logic        hit, m2, ok;
    logic [1:0]  m1;
    logic [15:0] pf;
    wire         i1 = bus_control_input_one;
    wire         i2 = bus_control_input_two;
    // pipelines still hold pre-reset samples for a few edges
    always_ff @(posedge core_clk) up <= !rst_n ? 3'h0 : (up == 3'h4 ? up : up + 3'h1);
    always_ff @(posedge core_clk) hit <= rst_n ? 1'b0 : (hit | flash_busy);
    // later config changes are ignored, so track only the loaded copy
    always_ff @(posedge core_clk) if (rst_n && up == 3'h0) {m1, m2, pf} <= {cfg_c1_mode,
        cfg_c2_mode, cfg_pin_func};
    assign ok = rst_n && up == 3'h4;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!ok);
    property p_read; m1 == 2'h0 || m1 == 2'h3 |-> read_low == $past(i1, 3); endproperty
    property p_phase; phase_clk == (m1 == 2'h1 && $past(i1, 3)); endproperty
    property p_strobe; data_strobe_low == (m1 == 2'h2 ? $past(i1, 3) : 1'b1); endproperty
    property p_fetch; {program_fetch_select, generic_input} ==
        {m2 | $past(i2, 3), m2 & $past(i2, 3)}; endproperty
    property p_terms; {logic_term_one, logic_term_two} == {$past(i1, 3), $past(i2, 3)};
    endproperty
    property p_rst; disable iff (1'b0) !rst_n |=> read_low && !flash_busy &&
        first_port_pins_oe == 8'h00; endproperty
    property p_abort; disable iff (1'b0) $rose(rst_n) && hit |-> ##[0:2] flash_aborted;
    endproperty
    property p_host_out; pf == 16'h0000 && $past(host_port_wr, 2) |->
        first_port_pins_out == $past(host_port_wdata, 2) && first_port_pins_oe == 8'hff;
    endproperty
    property p_logic_in; pf == 16'hffff |-> first_port_pins_oe == 8'h00 &&
        logic_array_port_in == $past(first_port_pins_in, 3); endproperty
    a_read: assert property (p_read) else $error("read line wrong");
    a_phase: assert property (p_phase) else $error("phase clock wrong");
    a_strobe: assert property (p_strobe) else $error("data strobe wrong");
    a_fetch: assert property (p_fetch) else $error("second input wrong");
    a_terms: assert property (p_terms) else $error("logic terms wrong");
    a_rst: assert property (p_rst) else $error("reset values wrong");
    a_abort: assert property (p_abort) else $error("flash not aborted");
    a_host_out: assert property (p_host_out) else $error("port write wrong");
    a_logic_in: assert property (p_logic_in) else $error("logic input wrong");
    c_fetch: cover property (m1 == 2'h3 && !read_low);
    c_abort: cover property (flash_aborted);
    c_logic: cover property (pf == 16'hffff && logic_array_port_in != 8'h00);
endmodule : mcp_chk
bind mcp_control_port mcp_chk chk (.*);

// *** tb/mcp_host.sv ***
// host model driving reset and the two control pins
// assumes callers act just after a rising edge
`timescale 1ns/10ps
module mcp_host (
    // clock
    input wire logic core_clk,
    // pins toward the device
    output logic     rst_n,
    output logic     bus_control_input_one,
    output logic     bus_control_input_two
);
    // low from power-up, before any edge
    initial rst_n = 1'b0;
    initial {bus_control_input_one, bus_control_input_two} = 2'b11;
    task automatic hold_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(posedge core_clk);
        #1 rst_n = 1'b1;
    endtask : hold_reset
    // fetch select lands on input one as the read line
    task automatic pins(input logic a, input logic b);
        {bus_control_input_one, bus_control_input_two} = {a, b};
    endtask : pins
endmodule : mcp_host

// *** tb/testbench.sv ***
// self-checking bench for the control input and first port block
// assumes the host model owns reset and the control pins
`timescale 1ns/10ps
module testbench;
    logic core_clk, rst_n, bus_control_input_one, bus_control_input_two, cfg_c2_mode;
    logic host_port_wr, flash_start, flash_busy, flash_aborted, read_low, phase_clk;
    logic data_strobe_low, program_fetch_select, generic_input, logic_term_one, logic_term_two;
    logic [1:0]  cfg_c1_mode;
    logic [15:0] cfg_pin_func;
    logic [7:0]  host_port_wdata, first_port_macrocells, first_port_pins_in;
    logic [7:0]  first_port_pins_out, first_port_pins_oe, host_port_rdata, logic_array_port_in;
    logic        flash_done;
    int          error_cnt = 0;
    int          comparisons = 0;
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    mcp_host host (.*);
    mcp_control_port dut (.*);
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic start(input logic [1:0] c, input logic m, input logic [15:0] pf);
        {cfg_c1_mode, cfg_c2_mode, cfg_pin_func} = {c, m, pf};
        host.hold_reset(5);
        step(2);
        // scrambled config must not take effect before next reset
        {cfg_c1_mode, cfg_c2_mode, cfg_pin_func} = ~{c, m, pf};
    endtask : start
    task automatic test_modes;
        logic [1:0] c;
        logic       v;
        logic [7:0] seen_c;
        logic [7:0] exp_c;
        for (int m = 0; m < 8; m++) begin
            c = m[2:1];
            start(c, m[0], 16'h5555);
            for (int k = 0; k < 2; k++) begin
                v = k[0];
                host.pins(v, ~v);
                step(4);
                seen_c = {1'b0, read_low, phase_clk, data_strobe_low, program_fetch_select,
                    generic_input, logic_term_one, logic_term_two};
                exp_c = {1'b0, c == 2'h0 || c == 2'h3 ? v : 1'b1, c == 2'h1 & v,
                    c == 2'h2 ? v : 1'b1, m[0] | ~v, m[0] & ~v, v, ~v};
                chk("control", seen_c, exp_c);
            end
        end
        $display("modes done");
    endtask : test_modes
    task automatic test_port;
        logic [7:0] exp_o;
        for (int f = 0; f < 4; f++) begin
            start(2'h0, 1'b0, {8{f[1:0]}});
            {host_port_wdata, first_port_pins_in, first_port_macrocells} = 24'h5a963c;
            host_port_wr = 1'b1;
            step(1);
            host_port_wr = 1'b0;
            step(3);
            chk("oe", first_port_pins_oe, f[0] ? 8'h00 : 8'hff);
            exp_o = f == 0 ? 8'h5a : f == 2 ? 8'h3c : 8'h00;
            chk("out", first_port_pins_out & first_port_pins_oe, exp_o);
            chk("rdata", host_port_rdata, f == 0 ? 8'h5a : f == 1 ? 8'h96 : 8'h00);
            chk("array", logic_array_port_in, f == 3 ? 8'h96 : 8'h00);
        end
        $display("port done");
    endtask : test_port
    task automatic test_flash;
        start(2'h0, 1'b0, 16'h0000);
        flash_start = 1'b1;
        step(1);
        flash_start = 1'b0;
        step(2);
        chk("busy", flash_busy, 8'h01);
        flash_done = 1'b1;
        step(1);
        flash_done = 1'b0;
        step(2);
        chk("done", {flash_busy, flash_aborted}, 8'h00);
        flash_start = 1'b1;
        step(1);
        flash_start = 1'b0;
        step(2);
        start(2'h0, 1'b0, 16'h0000);
        chk("aborted", {flash_busy, flash_aborted}, 8'h01);
        flash_start = 1'b1;
        step(1);
        flash_start = 1'b0;
        step(2);
        chk("restart", {flash_busy, flash_aborted}, 8'h02);
        $display("flash done");
    endtask : test_flash
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        {cfg_c1_mode, cfg_c2_mode, cfg_pin_func, host_port_wr, flash_start, flash_done} = '0;
        {host_port_wdata, first_port_macrocells, first_port_pins_in} = '0;
        test_modes;
        test_port;
        test_flash;
        stop_test;
    end
    // whole run is about 190 rising edges
    initial begin
        #20000;
        error_cnt++;
        stop_test;
    end
endmodule : testbench
